// ==== pwm12_regs.svh ====
// register offsets, field positions and constants of the 12-bit modulator
`ifndef PWM12_REGS_SVH
`define PWM12_REGS_SVH

// register indexes; byte address is four times the index
`define IDX_DEAD_GAP   8'hD1
`define IDX_CONTROL    8'hD2
`define IDX_PERIOD_LO  8'hD3
`define IDX_PERIOD_HI  8'hD4
`define IDX_DUTY_LO    8'hD5
`define IDX_DUTY_HI    8'hD6
`define IDX_ENABLE     8'hCF
`define IDX_LOCK       8'hE7

// enable register fields
`define EN_MODULE_ON   7
`define EN_TRIP_IN     6
`define EN_COMP_LSB    3
`define EN_PRIM_LSB    0

// control register fields
`define CT_IRQ_EN      7
`define CT_IRQ_FLAG    6
`define CT_PRE_MSB     5
`define CT_TRIP_STATE  4
`define CT_TRIP_LEVEL  3
`define CT_POLARITY    2
`define CT_PRE_LOW_LSB 0

`define LOCK_KEY       8'h55
`define RESET_BYTE     8'h00
`define RESET_WORD12   12'h000

// prescaler codes
`define PRE_DIV2       3'h0
`define PRE_DIV4       3'h1
`define PRE_DIV8       3'h2
`define PRE_DIV16      3'h3
`define PRE_DIV12      3'h4
`define PRE_DIV32      3'h5

// least dead gap in oscillator clocks
`define DEAD_MIN       8'h02

`endif

// ==== pwm12_pkg.sv ====
// types shared by the modulator and its users
package pwm12_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
  } wb_rsp_t;

  typedef struct packed {
    logic [2:0] level;
    logic [2:0] oe;
  } pin_group_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_ACTIVE = 2'b01,
    PH_REST   = 2'b10
  } phase_t;

endpackage

// ==== pwm12_complementary_deadtime.sv ====
// 12-bit modulator with complementary outputs, dead gap and trip input
// Summary of operation
// - enable bit 7 turns modulator on
// - bit 6 makes trip pin active
// - bits 5..3 enable complementary outputs
// - bits 2..0 enable primary outputs
// - zero enable word stops all outputs
// - trip forces every output inactive
// - level select picks trip pin level
// - trip flag holds; clear fails during fault
// - locked registers writable only with key
// - overflow flag; request needs both enables
// - three-bit prescaler divides oscillator clock
// - polarity bit selects output sense
// - zero period gives constant inactive primary
// - duty at or above period: constant active
// - settings change at period end, while off, or at zero period
// - low byte applies after high byte
// - complementary is inverse of primary, except both inactive at zero period
// - complementary runs without primary enabled
// - dead gap counts raw clocks, least two unless zero
// - dead gap taken only while disabled
// - short rest keeps complementary constant
//
// The Wishbone slave port was chosen for this implementation.
`include "pwm12_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pwm12_complementary_deadtime #(
  parameter int CNT_W = 12,
  parameter int SYNC_STAGES = 2
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire pwm12_pkg::wb_req_t    wb_req,
  output var  pwm12_pkg::wb_rsp_t    wb_rsp,
  input  wire logic                  trip_pin,
  input  wire logic                  global_modulator_irq_enable,
  output logic                       irq_req,
  output var  pwm12_pkg::pin_group_t primary_pins,
  output var  pwm12_pkg::pin_group_t comp_pins
);
  import pwm12_pkg::*;

  // bus decode
  logic             ack_q;
  logic [31:0]      rdat_q;
  logic [7:0]       idx;
  logic             take;
  logic             wr;
  logic [7:0]       wbyte;
  logic             key_ok;

  // registers seen by software
  logic [7:0]       enable_q;
  logic [7:0]       lock_q;
  logic [7:0]       dead_q;
  logic             irq_en_q;
  logic             irq_flag_q;
  logic             trip_flag_q;
  logic             trip_lvl_q;
  logic             pol_w_q;
  logic [2:0]       pre_w_q;
  logic [CNT_W-1:0] period_w_q;
  logic [CNT_W-1:0] duty_w_q;
  logic [7:0]       period_lo_q;
  logic [7:0]       duty_lo_q;

  // settings in force for the running period
  logic             pol_q;
  logic [2:0]       pre_q;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] duty_q;
  logic [7:0]       dead_cap_q;

  // timing
  logic [7:0]       div_q;
  logic [7:0]       div_end;
  logic             tick;
  logic [CNT_W-1:0] cnt_q;
  logic             wrap;
  logic             reload;
  phase_t           phase;
  logic             active;
  logic             act_q;
  logic [7:0]       gap_q;
  logic [7:0]       dead_eff;
  logic             in_gap;
  logic [CNT_W-1:0] rest_len;
  logic             rest_short;

  // trip path
  logic [SYNC_STAGES-1:0] trip_sync_q;
  logic             trip_seen;
  logic             fault;
  logic             held;

  logic             module_on;
  logic             prim_on;
  logic             comp_on;

  assign module_on = enable_q[`EN_MODULE_ON];

  // classic wishbone slave, one wait state; ack drops the cycle after
  assign take  = wb_req.cyc & wb_req.stb;
  assign idx   = wb_req.adr[9:2];
  assign wr    = take & wb_req.we & ack_q & wb_req.sel[0];
  assign wbyte = wb_req.dat[7:0];
  assign key_ok = (lock_q == `LOCK_KEY);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take & ~ack_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdat_q <= 32'h0000_0000;
    end else if (take & ~ack_q) begin
      rdat_q <= 32'h0000_0000;
      unique case (idx)
        `IDX_ENABLE:    rdat_q[7:0] <= enable_q;
        `IDX_LOCK:      rdat_q[7:0] <= lock_q;
        `IDX_DEAD_GAP:  rdat_q[7:0] <= dead_q;
        `IDX_CONTROL:   rdat_q[7:0] <= {irq_en_q, irq_flag_q,
                                        pre_w_q[2], trip_flag_q,
                                        trip_lvl_q, pol_w_q,
                                        pre_w_q[1:0]};
        `IDX_PERIOD_LO: rdat_q[7:0] <= period_w_q[7:0];
        `IDX_PERIOD_HI: rdat_q[3:0] <= period_w_q[11:8];
        `IDX_DUTY_LO:   rdat_q[7:0] <= duty_w_q[7:0];
        `IDX_DUTY_HI:   rdat_q[3:0] <= duty_w_q[11:8];
        default:        rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_rsp.ack = ack_q;
  assign wb_rsp.dat = rdat_q;

  // lock key itself is always writable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_q <= `RESET_BYTE;
    end else if (wr && idx == `IDX_LOCK) begin
      lock_q <= wbyte;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_q <= `RESET_BYTE;
    end else if (wr && idx == `IDX_ENABLE && key_ok) begin
      enable_q <= wbyte;
    end
  end

  // dead gap accepted only while the modulator is off
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dead_q <= `RESET_BYTE;
    end else if (wr && idx == `IDX_DEAD_GAP && !module_on) begin
      dead_q <= wbyte;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dead_cap_q <= `RESET_BYTE;
    end else if (!module_on) begin
      dead_cap_q <= dead_q;
    end
  end

  // plain control bits, guarded by the key
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_en_q   <= 1'b0;
      trip_lvl_q <= 1'b0;
      pol_w_q    <= 1'b0;
      pre_w_q    <= `PRE_DIV2;
    end else if (wr && idx == `IDX_CONTROL && key_ok) begin
      irq_en_q   <= wbyte[`CT_IRQ_EN];
      trip_lvl_q <= wbyte[`CT_TRIP_LEVEL];
      pol_w_q    <= wbyte[`CT_POLARITY];
      pre_w_q    <= {wbyte[`CT_PRE_MSB],
                     wbyte[`CT_PRE_LOW_LSB+1:`CT_PRE_LOW_LSB]};
    end
  end

  // overflow flag: hardware set beats a software clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_flag_q <= 1'b0;
    end else if (wrap) begin
      irq_flag_q <= 1'b1;
    end else if (wr && idx == `IDX_CONTROL && key_ok &&
                 !wbyte[`CT_IRQ_FLAG]) begin
      irq_flag_q <= 1'b0;
    end
  end

  assign irq_req = irq_en_q & irq_flag_q &
                   global_modulator_irq_enable;

  // low bytes wait in staging until the high byte lands
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      period_lo_q <= `RESET_BYTE;
      period_w_q  <= `RESET_WORD12;
    end else if (wr && key_ok) begin
      if (idx == `IDX_PERIOD_LO) begin
        period_lo_q <= wbyte;
      end else if (idx == `IDX_PERIOD_HI) begin
        period_w_q <= {wbyte[3:0], period_lo_q};
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      duty_lo_q <= `RESET_BYTE;
      duty_w_q  <= `RESET_WORD12;
    end else if (wr && key_ok) begin
      if (idx == `IDX_DUTY_LO) begin
        duty_lo_q <= wbyte;
      end else if (idx == `IDX_DUTY_HI) begin
        duty_w_q <= {wbyte[3:0], duty_lo_q};
      end
    end
  end

  // running settings move only at a period boundary, while off, or at zero period
  assign reload = !module_on || wrap || (period_q == `RESET_WORD12);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pol_q    <= 1'b0;
      pre_q    <= `PRE_DIV2;
      period_q <= `RESET_WORD12;
      duty_q   <= `RESET_WORD12;
    end else if (reload) begin
      pol_q    <= pol_w_q;
      pre_q    <= pre_w_q;
      period_q <= period_w_q;
      duty_q   <= duty_w_q;
    end
  end

  // prescaler; codes beyond the printed ones fall to the slowest
  always_comb begin
    unique case (pre_q)
      `PRE_DIV2:  div_end = 8'h01;
      `PRE_DIV4:  div_end = 8'h03;
      `PRE_DIV8:  div_end = 8'h07;
      `PRE_DIV16: div_end = 8'h0F;
      `PRE_DIV12: div_end = 8'h0B;
      `PRE_DIV32: div_end = 8'h1F;
      default:    div_end = 8'hFF;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= 8'h00;
    end else if (!module_on || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign tick = module_on && (div_q >= div_end);
  assign wrap = tick && (period_q != `RESET_WORD12) &&
                (cnt_q >= period_q - 12'h001);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= `RESET_WORD12;
    end else if (!module_on || wrap) begin
      cnt_q <= `RESET_WORD12;
    end else if (tick) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  // active while count below duty; constant cases override
  always_comb begin
    if (period_q == `RESET_WORD12) begin
      phase = PH_IDLE;
    end else if (duty_q >= period_q) begin
      phase = PH_ACTIVE;
    end else if (cnt_q < duty_q) begin
      phase = PH_ACTIVE;
    end else begin
      phase = PH_REST;
    end
  end

  assign active = module_on && (phase == PH_ACTIVE);

  // gap length in raw clocks; zero means no gap, else never under the least value
  assign dead_eff = (dead_cap_q == 8'h00) ? 8'h00 :
                    (dead_cap_q < `DEAD_MIN) ? `DEAD_MIN :
                    dead_cap_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      act_q <= 1'b0;
    end else begin
      act_q <= active;
    end
  end

  // gap counter restarts on every edge of the raw waveform
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_q <= 8'h00;
    end else if (active != act_q && dead_eff != 8'h00) begin
      gap_q <= dead_eff - 8'h01;
    end else if (gap_q != 8'h00) begin
      gap_q <= gap_q - 8'h01;
    end
  end

  assign in_gap = (dead_eff != 8'h00) &&
                  ((active != act_q) || (gap_q != 8'h00));

  // too little rest time to fit two gaps
  assign rest_len   = period_q - duty_q;
  assign rest_short = (duty_q >= period_q) ||
                      ({1'b0, rest_len} <=
                       {4'h0, dead_eff, 1'b0});

  assign prim_on = active && !in_gap;
  assign comp_on = module_on && !active && !in_gap &&
                   !rest_short && (period_q != `RESET_WORD12);

  // trip pin crosses into the clock domain first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trip_sync_q <= '0;
    end else begin
      trip_sync_q <= {trip_sync_q[SYNC_STAGES-2:0], trip_pin};
    end
  end

  assign trip_seen = trip_sync_q[SYNC_STAGES-1];
  assign fault = enable_q[`EN_TRIP_IN] &&
                 (trip_seen == trip_lvl_q);

  // flag holds until cleared; a clear during the fault is lost
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trip_flag_q <= 1'b0;
    end else if (fault) begin
      trip_flag_q <= 1'b1;
    end else if (wr && idx == `IDX_CONTROL && key_ok &&
                 !wbyte[`CT_TRIP_STATE]) begin
      trip_flag_q <= 1'b0;
    end
  end

  assign held = fault || trip_flag_q;

  // pins: levels and enables from flops, one channel per loop pass
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_ch
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          primary_pins.level[ch] <= 1'b0;
          primary_pins.oe[ch]    <= 1'b0;
          comp_pins.level[ch]    <= 1'b0;
          comp_pins.oe[ch]       <= 1'b0;
        end else begin
          primary_pins.oe[ch] <= module_on &&
                                 enable_q[`EN_PRIM_LSB+ch];
          comp_pins.oe[ch]    <= module_on &&
                                 enable_q[`EN_COMP_LSB+ch];
          // inactive level equals the polarity bit
          primary_pins.level[ch] <= held ? pol_q :
                                    (prim_on ^ pol_q);
          comp_pins.level[ch]    <= held ? pol_q :
                                    (comp_on ^ pol_q);
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ==== pwm12_monitor.sv ====
// port assertions for the 12-bit modulator
`timescale 1ns/1ps
`default_nettype none
module pwm12_monitor (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire pwm12_pkg::wb_req_t    wb_req,
  input wire pwm12_pkg::wb_rsp_t    wb_rsp,
  input wire logic                  trip_pin,
  input wire logic                  global_modulator_irq_enable,
  input wire logic                  irq_req,
  input wire pwm12_pkg::pin_group_t primary_pins,
  input wire pwm12_pkg::pin_group_t comp_pins
);
  import pwm12_pkg::*;
  wire logic req_on = wb_req.cyc && wb_req.stb;
  wire logic wr_ack = wb_rsp.ack && wb_req.we;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_ack_answer: assert property ($rose(req_on) |=> wb_rsp.ack)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held longer than one cycle");
  a_no_idle_ack: assert property (!req_on |=> !wb_rsp.ack)
    else $error("ack without a request");
  a_read_upper: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  a_irq_gated: assert property (irq_req |-> global_modulator_irq_enable)
    else $error("interrupt request without global enable");
  a_irq_drop: assert property ($fell(global_modulator_irq_enable) |-> !irq_req)
    else $error("interrupt request stayed after global disable");
  // pin enables only move after a register write
  a_oe_by_write: assert property ($changed({primary_pins.oe, comp_pins.oe}) |->
    $past(wr_ack) || $past(wr_ack, 2) || $past(wr_ack, 3))
    else $error("pin enable changed without a write");
  a_reset_quiet: assert property ($fell(reset) |->
    primary_pins == '0 && comp_pins == '0 && !wb_rsp.ack)
    else $error("outputs not quiet after reset");
endmodule

bind pwm12_complementary_deadtime pwm12_monitor i_pwm12_monitor (
  .clk(clk), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .trip_pin(trip_pin),
  .global_modulator_irq_enable(global_modulator_irq_enable),
  .irq_req(irq_req), .primary_pins(primary_pins), .comp_pins(comp_pins));
`default_nettype wire

// ==== pwm12_switch_model.sv ====
// power stage model: fault sense source and shoot-through watch
`timescale 1ns/1ps
`default_nettype none
module pwm12_switch_model (
  input  wire logic                  clk,
  input  wire pwm12_pkg::pin_group_t primary_pins,
  input  wire pwm12_pkg::pin_group_t comp_pins,
  input  wire logic                  polarity,
  input  wire logic                  fault_now,
  input  wire logic                  trip_high,
  output logic                       trip_pin,
  output int                         shoot_count
);
  import pwm12_pkg::*;
  // sense line has no pull, so it is always driven
  assign trip_pin = fault_now ? trip_high : !trip_high;
  initial shoot_count = 0;
  // both switches of one leg on at once would short the supply
  always @(posedge clk) begin
    if (|(primary_pins.oe & comp_pins.oe & (primary_pins.level ^ {3{polarity}})
        & (comp_pins.level ^ {3{polarity}}))) begin
      shoot_count <= shoot_count + 1;
    end
  end
endmodule
`default_nettype wire

// ==== test_pwm12_complementary_deadtime.sv ====
// self-checking bench for the 12-bit modulator
`timescale 1ns/1ps
`default_nettype none
`include "pwm12_regs.svh"
module test_pwm12_complementary_deadtime;
  import pwm12_pkg::*;
  typedef struct packed {logic we; logic [7:0] idx, d, exp;} row_t;
  localparam row_t rows [17] = '{
    '{1'b0, `IDX_ENABLE, 8'h00, 8'h00}, '{1'b1, `IDX_ENABLE, 8'h89, 8'h00},
    '{1'b0, `IDX_ENABLE, 8'h00, 8'h00}, '{1'b1, `IDX_LOCK, 8'h55, 8'h00},
    '{1'b1, `IDX_PERIOD_LO, 8'h08, 8'h00},
    '{1'b0, `IDX_PERIOD_LO, 8'h00, 8'h00},
    '{1'b1, `IDX_PERIOD_HI, 8'h00, 8'h00},
    '{1'b0, `IDX_PERIOD_LO, 8'h00, 8'h08},
    '{1'b1, `IDX_DUTY_LO, 8'h02, 8'h00}, '{1'b1, `IDX_DUTY_HI, 8'h00, 8'h00},
    '{1'b0, `IDX_DUTY_LO, 8'h00, 8'h02}, '{1'b1, `IDX_DEAD_GAP, 8'h00, 8'h00},
    '{1'b1, `IDX_DEAD_GAP, 8'h02, 8'h00}, '{1'b0, `IDX_DEAD_GAP, 8'h00, 8'h02},
    '{1'b1, 8'h10, 8'hAA, 8'h00}, '{1'b0, 8'h10, 8'h00, 8'h00},
    '{1'b1, `IDX_CONTROL, 8'h00, 8'h00}};
  logic       clk = 0, reset = 1, irq_en = 0, pol = 0, fault = 0;
  logic       irq_req, trip_pin;
  wb_req_t    req = '0;
  wb_rsp_t    rsp;
  pin_group_t prim, comp;
  int         fail_count = 0, samples_checked = 0, cycles = 0, shoots;

  pwm12_complementary_deadtime i_pwm12_complementary_deadtime (
    .clk(clk), .reset(reset), .wb_req(req), .wb_rsp(rsp),
    .trip_pin(trip_pin), .global_modulator_irq_enable(irq_en),
    .irq_req(irq_req), .primary_pins(prim), .comp_pins(comp));
  pwm12_switch_model i_pwm12_switch_model (
    .clk(clk), .primary_pins(prim), .comp_pins(comp), .polarity(pol),
    .fault_now(fault), .trip_high(1'b1), .trip_pin(trip_pin),
    .shoot_count(shoots));

  always #50 clk = ~clk;

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // entered at a rising edge; request held until ack is sampled
  task automatic xfer(input logic we, input logic [7:0] idx, d,
                      output logic [31:0] rd);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hF,
             dat: {24'h0, d}};
    do @(posedge clk); while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, d);
    logic [31:0] rd;
    xfer(1'b1, idx, d, rd);
  endtask

  // 32 clocks are exactly two periods of eight at divide by two
  task automatic watch(output int hp, hc, lo);
    hp = 0; hc = 0; lo = 0;
    repeat (32) begin
      @(posedge clk);
      hp += int'(prim.level[0]);
      hc += int'(comp.level[0]);
      lo += int'(prim.level[0] == pol && comp.level[0] == pol);
    end
  endtask

  initial begin
    logic [31:0] v;
    int hp, hc, lo;
    repeat (3) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    foreach (rows[i]) begin
      xfer(rows[i].we, rows[i].idx, rows[i].d, v);
      if (!rows[i].we) check(v, {24'h0, rows[i].exp});
    end
    wr(`IDX_ENABLE, 8'h89);
    repeat (25) @(posedge clk);
    check(32'({prim.oe, comp.oe}), 32'h09);
    watch(hp, hc, lo);
    check(32'(hp), 32'd4);
    check(32'(hc), 32'd20);
    check(32'(lo), 32'd8);
    wr(`IDX_DEAD_GAP, 8'h05);
    xfer(1'b0, `IDX_DEAD_GAP, 8'h00, v);
    check(v, 32'h02);
    wr(`IDX_DUTY_LO, 8'h04);
    wr(`IDX_DUTY_HI, 8'h00);
    repeat (25) @(posedge clk);
    watch(hp, hc, lo);
    check(32'(hc), 32'd0);
    // polarity moves while the pins are released, so the stage model agrees
    wr(`IDX_ENABLE, 8'h00);
    wr(`IDX_DEAD_GAP, 8'h00);
    wr(`IDX_DEAD_GAP, 8'h02);
    wr(`IDX_CONTROL, 8'h0C);
    pol <= 1;
    wr(`IDX_ENABLE, 8'hC9);
    fault <= 1;
    repeat (6) @(posedge clk);
    check(32'({prim.level[0], comp.level[0]}), 32'h3);
    wr(`IDX_CONTROL, 8'h0C);
    xfer(1'b0, `IDX_CONTROL, 8'h00, v);
    check(v & 32'h10, 32'h10);
    fault <= 0;
    repeat (25) @(posedge clk);
    check(32'({prim.level[0], comp.level[0]}), 32'h3);
    wr(`IDX_CONTROL, 8'h0C);
    xfer(1'b0, `IDX_CONTROL, 8'h00, v);
    check(v & 32'h10, 32'h00);
    wr(`IDX_ENABLE, 8'h89);
    fault <= 1;
    repeat (25) @(posedge clk);
    watch(hp, hc, lo);
    check(32'(hp), 32'd20);
    wr(`IDX_CONTROL, 8'h8C);
    irq_en <= 1;
    repeat (25) @(posedge clk);
    check(32'(irq_req), 32'h1);
    irq_en <= 0;
    @(posedge clk);
    check(32'(irq_req), 32'h0);
    // duty beyond the period holds the primary active (low at polarity 1)
    wr(`IDX_DUTY_LO, 8'h0A);
    wr(`IDX_DUTY_HI, 8'h00);
    repeat (25) @(posedge clk);
    watch(hp, hc, lo);
    check(32'(hp), 32'd0);
    // zero period holds the primary inactive (high at polarity 1)
    wr(`IDX_PERIOD_LO, 8'h00);
    wr(`IDX_PERIOD_HI, 8'h00);
    repeat (25) @(posedge clk);
    watch(hp, hc, lo);
    check(32'(hp), 32'd32);
    // complementary B and C, primary B alone, so C runs without its primary
    wr(`IDX_ENABLE, 8'hB2);
    repeat (3) @(posedge clk);
    check(32'({prim.oe, comp.oe}), 32'h16);
    wr(`IDX_ENABLE, 8'h00);
    repeat (3) @(posedge clk);
    check(32'({prim.oe, comp.oe}), 32'h00);
    check(32'(shoots), 32'd0);
    wr(`IDX_LOCK, 8'h00);
    wr(`IDX_ENABLE, 8'hFF);
    xfer(1'b0, `IDX_ENABLE, 8'h00, v);
    check(v, 32'h00);
    reset <= 1;
    repeat (3) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    xfer(1'b0, `IDX_PERIOD_LO, 8'h00, v);
    check(v, 32'h00);
    finish_test();
  end
endmodule
`default_nettype wire
